// ==== src/can_obj_pkg.sv ====
// Purpose: Shared constants and types of the CAN message-object store.
// Assumes: One 100 MHz clock; registers reached over classic Wishbone.
// Notes: Register map, field positions, object kinds and frame layout.
package can_obj_pkg;
    localparam int OBJ_COUNT = 32;
    localparam int IDX_W = 5;
    localparam int ID_W = 29;
    localparam int STD_ID_W = 11;
    localparam int DLC_W = 4;
    localparam logic [DLC_W-1:0] MAX_BYTES = 4'h8;
    localparam int ADR_W = 8;

    // Object kinds.
    localparam logic [2:0] KIND_PLAIN_TRANSMIT = 3'h0;
    localparam logic [2:0] KIND_PLAIN_RECEIVE = 3'h1;
    localparam logic [2:0] KIND_REMOTE_SEND = 3'h2;
    localparam logic [2:0] KIND_REMOTE_ACCEPT = 3'h3;
    localparam logic [2:0] KIND_AUTO_REPLY = 3'h4;

    // Byte offsets of the registers.
    localparam logic [ADR_W-1:0] OFF_SELECT = 8'h00;
    localparam logic [ADR_W-1:0] OFF_CONFIG = 8'h04;
    localparam logic [ADR_W-1:0] OFF_IDENT = 8'h08;
    localparam logic [ADR_W-1:0] OFF_MASK = 8'h0C;
    localparam logic [ADR_W-1:0] OFF_DATA_LO = 8'h10;
    localparam logic [ADR_W-1:0] OFF_DATA_HI = 8'h14;
    localparam logic [ADR_W-1:0] OFF_STATUS = 8'h18;
    localparam logic [ADR_W-1:0] OFF_TX_MAP = 8'h1C;
    localparam logic [ADR_W-1:0] OFF_FRESH_MAP = 8'h20;
    localparam logic [ADR_W-1:0] OFF_VALID_MAP = 8'h24;
    localparam logic [ADR_W-1:0] OFF_IRQ_MAP = 8'h28;

    // Configuration word: flags [6:0], kind [9:7], byte count [19:16].
    localparam int CFG_FLAGS_LSB = 3;
    localparam int CFG_DLC_LSB = 16;

    // Command bits written to the status offset.
    localparam int CMD_ACK_BIT = 0;
    localparam int CMD_TX_BIT = 1;
    localparam int CMD_VALID_SET_BIT = 2;
    localparam int CMD_VALID_CLR_BIT = 3;

    typedef struct packed {
        logic [2:0] kind;
        logic chain;
        logic rx_irq;
        logic tx_irq;
        logic ext;
        logic ext_only;
        logic dir_filt;
        logic id_filt;
    } obj_cfg_t;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic ext;
        logic rtr;
        logic [DLC_W-1:0] dlc;
        logic [63:0] data;
    } can_frame_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tx_state_t;
endpackage

// ==== src/lowest_set.sv ====
// Purpose: Finds the lowest set bit of a 32-bit request vector.
// Assumes: Purely combinational.
// Notes: Low index wins, which gives FIFO order and object priority.
`timescale 1ns/10ps
module lowest_set
    import can_obj_pkg::*;
(
    // Request vector and result.
    input wire logic [OBJ_COUNT-1:0] req,
    output logic found,
    output logic [IDX_W-1:0] index
);
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = OBJ_COUNT - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                index = IDX_W'(i);
            end
        end
    end
endmodule // lowest_set

// ==== src/can_msg_objects.sv ====
// Purpose: Message-object store, acceptance filter and reply logic of a CAN controller.
// Assumes: Frame engine on REF_CLK delivers one-cycle RX_VALID and TX_DONE pulses.
// Notes: Objects are reached through a select register and windowed fields.
`timescale 1ns/10ps
module can_msg_objects
    import can_obj_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RESET,
    // Wishbone slave.
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Frames from the frame engine.
    input wire logic RX_VALID,
    input wire can_frame_t RX_FRAME,
    // Frames to the frame engine.
    output logic TX_VALID,
    output can_frame_t TX_FRAME,
    input wire logic TX_DONE,
    // Object event summary.
    output logic IRQ_PENDING
);
    obj_cfg_t cfg [OBJ_COUNT];
    logic [ID_W-1:0] ident [OBJ_COUNT];
    logic [ID_W-1:0] mask [OBJ_COUNT];
    logic [DLC_W-1:0] dlc [OBJ_COUNT];
    logic [63:0] data [OBJ_COUNT];
    logic [OBJ_COUNT-1:0] fresh, overwrite, remote_seen, tx_pending, valid, irq_flag;
    logic [IDX_W-1:0] sel;
    logic [OBJ_COUNT-1:0] elig;
    logic rx_hit, tx_hit, rx_store, tx_done;
    logic [IDX_W-1:0] rx_idx, tx_cand, tx_idx;
    tx_state_t tx_state;
    logic bus_req, wr;
    logic [31:0] next_rdata;
    logic [31:0] wmerged;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // A longer count would overrun the eight-byte store.
    function automatic logic [DLC_W-1:0] clamp_dlc(input logic [DLC_W-1:0] n);
        return (n > MAX_BYTES) ? MAX_BYTES : n;
    endfunction

    function automatic logic obj_match(input obj_cfg_t c, input logic [ID_W-1:0] oid, input logic [ID_W-1:0] msk,
                                       input can_frame_t f);
        logic takes, id_ok, dir_ok, ext_ok;
        takes = (c.kind == KIND_PLAIN_RECEIVE) || (c.kind == KIND_REMOTE_ACCEPT) || (c.kind == KIND_AUTO_REPLY);
        id_ok = c.id_filt ? ((f.id & msk) == oid) : (f.id == oid);
        dir_ok = !c.dir_filt || (f.rtr == (c.kind != KIND_PLAIN_RECEIVE));
        ext_ok = !c.ext_only || f.ext;
        return takes && id_ok && dir_ok && ext_ok && !(f.rtr && c.kind == KIND_PLAIN_RECEIVE);
    endfunction

    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr = bus_req && WB_WE_I;
    assign rx_store = RX_VALID && rx_hit;
    assign tx_done = (tx_state == TX_SEND) && TX_DONE;

    always_comb begin
        case (WB_ADR_I)
            OFF_CONFIG: wmerged = merge({12'h000, dlc[sel], 6'h00, cfg[sel]}, WB_DAT_I, WB_SEL_I);
            OFF_IDENT: wmerged = merge({3'h0, ident[sel]}, WB_DAT_I, WB_SEL_I);
            OFF_MASK: wmerged = merge({3'h0, mask[sel]}, WB_DAT_I, WB_SEL_I);
            OFF_DATA_LO: wmerged = merge(data[sel][31:0], WB_DAT_I, WB_SEL_I);
            OFF_DATA_HI: wmerged = merge(data[sel][63:32], WB_DAT_I, WB_SEL_I);
            default: wmerged = merge({27'h0000000, sel}, WB_DAT_I, WB_SEL_I);
        endcase
    end

    // A full chain member is skipped; the last member has no chain flag and takes the overwrite.
    always_comb begin
        for (int i = 0; i < OBJ_COUNT; i++) begin
            elig[i] = valid[i] && obj_match(cfg[i], ident[i], mask[i], RX_FRAME) && !(cfg[i].chain && fresh[i]);
        end
    end

    lowest_set u_rx_pick (.req(elig), .found(rx_hit), .index(rx_idx));
    lowest_set u_tx_pick (.req(tx_pending & valid), .found(tx_hit), .index(tx_cand));

    // Object select register.
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            sel <= '0;
        end else if (wr && WB_ADR_I == OFF_SELECT) begin
            sel <= wmerged[IDX_W-1:0];
        end
    end

    // Object configuration and payload store.
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < OBJ_COUNT; i++) begin
                cfg[i] <= '0;
                ident[i] <= '0;
                mask[i] <= '0;
                dlc[i] <= '0;
                data[i] <= '0;
            end
        end else begin
            if (wr && WB_ADR_I == OFF_CONFIG) begin
                cfg[sel] <= obj_cfg_t'(wmerged[CFG_FLAGS_LSB+6:0]);
                dlc[sel] <= clamp_dlc(wmerged[CFG_DLC_LSB +: DLC_W]);
            end
            if (wr && WB_ADR_I == OFF_IDENT) begin
                ident[sel] <= wmerged[ID_W-1:0];
                if (wmerged[ID_W-1:STD_ID_W] != '0) begin
                    cfg[sel].ext <= 1'b1;
                end
            end
            if (wr && WB_ADR_I == OFF_MASK) begin
                mask[sel] <= wmerged[ID_W-1:0];
            end
            if (wr && WB_ADR_I == OFF_DATA_LO) begin
                data[sel][31:0] <= wmerged;
            end
            if (wr && WB_ADR_I == OFF_DATA_HI) begin
                data[sel][63:32] <= wmerged;
            end
            if (rx_store && !RX_FRAME.rtr) begin
                data[rx_idx] <= RX_FRAME.data;
                dlc[rx_idx] <= clamp_dlc(RX_FRAME.dlc);
            end
            if (tx_done && cfg[tx_idx].kind == KIND_REMOTE_SEND) begin
                cfg[tx_idx].kind <= KIND_PLAIN_RECEIVE;
            end
        end
    end

    // Object flags; clears are applied first so that a same-cycle event wins.
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            fresh <= '0;
            overwrite <= '0;
            remote_seen <= '0;
            tx_pending <= '0;
            valid <= '0;
            irq_flag <= '0;
        end else begin
            if (wr && WB_ADR_I == OFF_STATUS) begin
                if (WB_DAT_I[CMD_ACK_BIT]) begin
                    fresh[sel] <= 1'b0;
                    overwrite[sel] <= 1'b0;
                    remote_seen[sel] <= 1'b0;
                    irq_flag[sel] <= 1'b0;
                end
                if (WB_DAT_I[CMD_TX_BIT]) begin
                    tx_pending[sel] <= 1'b1;
                end
                if (WB_DAT_I[CMD_VALID_SET_BIT]) begin
                    valid[sel] <= 1'b1;
                end else if (WB_DAT_I[CMD_VALID_CLR_BIT]) begin
                    valid[sel] <= 1'b0;
                end
            end
            if (tx_done) begin
                tx_pending[tx_idx] <= wr && WB_ADR_I == OFF_STATUS && WB_DAT_I[CMD_TX_BIT] && sel == tx_idx;
                if (cfg[tx_idx].tx_irq) begin
                    irq_flag[tx_idx] <= 1'b1;
                end
            end
            if (rx_store && !RX_FRAME.rtr) begin
                fresh[rx_idx] <= 1'b1;
                if (fresh[rx_idx]) begin
                    overwrite[rx_idx] <= 1'b1;
                end
                if (cfg[rx_idx].rx_irq) begin
                    irq_flag[rx_idx] <= 1'b1;
                end
            end
            if (rx_store && RX_FRAME.rtr) begin
                remote_seen[rx_idx] <= 1'b1;
                if (cfg[rx_idx].kind == KIND_AUTO_REPLY) begin
                    tx_pending[rx_idx] <= 1'b1;
                end
                if (cfg[rx_idx].kind == KIND_REMOTE_ACCEPT || cfg[rx_idx].rx_irq) begin
                    irq_flag[rx_idx] <= 1'b1;
                end
            end
        end
    end

    // Transmit hand-off: the frame stands until the engine reports it sent.
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            tx_state <= TX_IDLE;
            TX_VALID <= 1'b0;
            TX_FRAME <= '0;
            tx_idx <= '0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (tx_hit) begin
                        tx_idx <= tx_cand;
                        TX_FRAME.id <= ident[tx_cand];
                        TX_FRAME.ext <= cfg[tx_cand].ext;
                        TX_FRAME.rtr <= (cfg[tx_cand].kind == KIND_REMOTE_SEND);
                        TX_FRAME.dlc <= dlc[tx_cand];
                        TX_FRAME.data <= data[tx_cand];
                        TX_VALID <= 1'b1;
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (TX_DONE) begin
                        TX_VALID <= 1'b0;
                        tx_state <= TX_IDLE;
                    end
                end
                default: begin
                    TX_VALID <= 1'b0;
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        case (WB_ADR_I)
            OFF_SELECT: next_rdata = {27'h0000000, sel};
            OFF_CONFIG: next_rdata = {12'h000, dlc[sel], 6'h00, cfg[sel]};
            OFF_IDENT: next_rdata = {3'h0, ident[sel]};
            OFF_MASK: next_rdata = {3'h0, mask[sel]};
            OFF_DATA_LO: next_rdata = data[sel][31:0];
            OFF_DATA_HI: next_rdata = data[sel][63:32];
            OFF_STATUS: next_rdata = {26'h0000000, irq_flag[sel], valid[sel], tx_pending[sel],
                                      remote_seen[sel], overwrite[sel], fresh[sel]};
            OFF_TX_MAP: next_rdata = tx_pending;
            OFF_FRESH_MAP: next_rdata = fresh;
            OFF_VALID_MAP: next_rdata = valid;
            OFF_IRQ_MAP: next_rdata = irq_flag;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Every access, mapped or not, is answered one cycle after it is presented.
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= (bus_req && !WB_WE_I) ? next_rdata : 32'h00000000;
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            IRQ_PENDING <= 1'b0;
        end else begin
            IRQ_PENDING <= |irq_flag;
        end
    end

    // Helper state for the checks below.
    logic chk_store, chk_rtr, chk_was_fresh, chk_auto;
    logic [IDX_W-1:0] chk_idx;
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            chk_store <= 1'b0;
            chk_rtr <= 1'b0;
            chk_was_fresh <= 1'b0;
            chk_auto <= 1'b0;
            chk_idx <= '0;
        end else begin
            chk_store <= rx_store;
            chk_rtr <= RX_FRAME.rtr;
            chk_was_fresh <= fresh[rx_idx];
            chk_auto <= cfg[rx_idx].kind == KIND_AUTO_REPLY;
            chk_idx <= rx_idx;
        end
    end

    a_fresh_on_store: assert property (@(posedge REF_CLK) disable iff (RESET)
        chk_store && !chk_rtr |-> fresh[chk_idx]) else $error("stored object not marked fresh");
    a_overwrite_set: assert property (@(posedge REF_CLK) disable iff (RESET)
        chk_store && !chk_rtr && chk_was_fresh |-> overwrite[chk_idx]) else $error("overwrite not flagged");
    a_remote_flag: assert property (@(posedge REF_CLK) disable iff (RESET)
        chk_store && chk_rtr |-> remote_seen[chk_idx]) else $error("remote request not flagged");
    a_auto_reply_queued: assert property (@(posedge REF_CLK) disable iff (RESET)
        chk_store && chk_rtr && chk_auto |-> tx_pending[chk_idx]) else $error("auto reply not queued");
    a_lowest_winner: assert property (@(posedge REF_CLK) disable iff (RESET)
        rx_store |-> (elig & ((32'h00000001 << rx_idx) - 32'h00000001)) == 32'h00000000)
        else $error("a lower object was eligible");
    a_chain_skip_full: assert property (@(posedge REF_CLK) disable iff (RESET)
        rx_store && !RX_FRAME.rtr |-> !(cfg[rx_idx].chain && fresh[rx_idx])) else $error("full chain member chosen");
    a_mask_compare: assert property (@(posedge REF_CLK) disable iff (RESET)
        rx_store && cfg[rx_idx].id_filt |-> (RX_FRAME.id & mask[rx_idx]) == ident[rx_idx])
        else $error("masked identifier mismatch accepted");
    a_ext_only: assert property (@(posedge REF_CLK) disable iff (RESET)
        rx_store && cfg[rx_idx].ext_only |-> RX_FRAME.ext) else $error("standard frame hit extended-only object");
    a_remote_convert: assert property (@(posedge REF_CLK) disable iff (RESET)
        tx_done && cfg[tx_idx].kind == KIND_REMOTE_SEND |=> cfg[$past(tx_idx)].kind == KIND_PLAIN_RECEIVE)
        else $error("remote send object not converted");
    a_tx_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
        TX_VALID && !TX_DONE |=> TX_VALID && $stable(TX_FRAME)) else $error("transmit frame dropped early");
    a_ack_single: assert property (@(posedge REF_CLK) disable iff (RESET)
        WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
endmodule // can_msg_objects

// ==== verification/can_frame_engine_model.sv ====
// Purpose: Frame engine that stands in for the other nodes on the bus.
// Assumes: Same clock as the object store; receive and done pulses last one cycle.
// Notes: Frame lines carry inverted data outside a receive pulse, so late sampling shows.
`timescale 1ns/10ps
module can_frame_engine_model
    import can_obj_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Frames towards the store.
    output logic rx_valid,
    output can_frame_t rx_frame,
    // Frames from the store.
    input wire logic tx_valid,
    input wire can_frame_t tx_frame,
    output logic tx_done,
    // Pacing and record.
    input wire logic [3:0] done_delay,
    output can_frame_t last_sent,
    output logic [7:0] sent_count
);
    logic [3:0] wait_count;

    initial begin
        rx_valid = 1'b0;
        rx_frame = '0;
    end

    task automatic send(input can_frame_t f);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_frame <= f;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_frame <= ~f;
    endtask

    // A slow delay lets the store hold its frame for several cycles before it is taken.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_done <= 1'b0;
            wait_count <= 4'h0;
            last_sent <= '0;
            sent_count <= 8'h00;
        end else if (tx_valid && !tx_done) begin
            if (wait_count == done_delay) begin
                tx_done <= 1'b1;
                last_sent <= tx_frame;
                sent_count <= sent_count + 8'h01;
                wait_count <= 4'h0;
            end else begin
                wait_count <= wait_count + 4'h1;
            end
        end else begin
            tx_done <= 1'b0;
        end
    end
endmodule // can_frame_engine_model

// ==== verification/test_can_msg_objects.sv ====
// Purpose: Self-checking bench of the message-object store.
// Assumes: Registers reached by classic Wishbone single cycles.
// Notes: The frame engine model supplies received frames and paces transmissions.
`timescale 1ns/10ps
module test_can_msg_objects
    import can_obj_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic rx_valid;
    can_frame_t rx_frame;
    logic tx_valid;
    can_frame_t tx_frame;
    logic tx_done;
    logic irq_pending;
    logic [3:0] tx_delay = 4'h3;
    logic [3:0] be = 4'hF;
    can_frame_t last_sent;
    logic [7:0] sent_count;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    always #5 ref_clk = ~ref_clk;

    can_msg_objects i_can_msg_objects (.REF_CLK(ref_clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(be), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .RX_VALID(rx_valid), .RX_FRAME(rx_frame), .TX_VALID(tx_valid), .TX_FRAME(tx_frame),
        .TX_DONE(tx_done), .IRQ_PENDING(irq_pending));

    can_frame_engine_model i_can_frame_engine_model (.clk(ref_clk), .reset(reset), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_done(tx_done),
        .done_delay(tx_delay), .last_sent(last_sent), .sent_count(sent_count));

    task automatic conclude();
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic exp_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic exp_obj(input logic [4:0] i, input logic [7:0] a, input logic [31:0] e, input string nm);
        wr(OFF_SELECT, {27'h0, i});
        exp_reg(a, e, nm);
    endtask

    task automatic setup(input logic [4:0] i, input logic [2:0] k, input logic [6:0] fl, input logic [3:0] l,
                         input logic [28:0] id, input logic [28:0] m);
        wr(OFF_SELECT, {27'h0, i});
        wr(OFF_CONFIG, {12'h0, l, 6'h0, k, fl});
        wr(OFF_IDENT, {3'h0, id});
        wr(OFF_MASK, {3'h0, m});
        wr(OFF_STATUS, 32'h4);
    endtask

    task automatic rx(input logic [28:0] id, input logic e, input logic r, input logic [63:0] d);
        i_can_frame_engine_model.send({id, e, r, 4'h8, d});
    endtask

    task automatic wait_sent(input logic [7:0] n);
        while (sent_count !== n) @(posedge ref_clk);
    endtask

    // The ceiling sits well above the few hundred cycles the sequence needs.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        exp_reg(OFF_VALID_MAP, 32'h0, "valid_map");
        exp_obj(5'h00, OFF_STATUS, 32'h0, "status0");
        wr(8'h40, 32'hFFFFFFFF);
        exp_reg(8'h40, 32'h0, "unmapped");
        setup(5'h03, KIND_PLAIN_RECEIVE, 7'h20, 4'h8, 29'h123, 29'h0);
        rx(29'h123, 1'b0, 1'b0, 64'h8877665544332211);
        exp_obj(5'h03, OFF_STATUS, 32'h31, "status3");
        chk("irq", 32'h1, {31'h0, irq_pending});
        exp_reg(OFF_DATA_LO, 32'h44332211, "data_lo");
        exp_reg(OFF_DATA_HI, 32'h88776655, "data_hi");
        exp_reg(OFF_FRESH_MAP, 32'h8, "fresh_map");
        i_can_frame_engine_model.send({29'h123, 1'b0, 1'b0, 4'h3, 64'hAA});
        exp_obj(5'h03, OFF_STATUS, 32'h33, "status3");
        exp_reg(OFF_CONFIG, 32'h300A0, "config3");
        wr(OFF_STATUS, 32'h1);
        exp_obj(5'h03, OFF_STATUS, 32'h10, "status3");
        chk("irq", 32'h0, {31'h0, irq_pending});
        rx(29'h123, 1'b0, 1'b1, 64'h0);
        exp_obj(5'h03, OFF_STATUS, 32'h10, "status3");
        setup(5'h05, KIND_PLAIN_RECEIVE, 7'h00, 4'h8, 29'h400, 29'h7F8);
        setup(5'h06, KIND_PLAIN_RECEIVE, 7'h01, 4'h8, 29'h400, 29'h7F8);
        rx(29'h405, 1'b0, 1'b0, 64'h5);
        exp_obj(5'h05, OFF_STATUS, 32'h10, "status5");
        exp_obj(5'h06, OFF_STATUS, 32'h11, "status6");
        rx(29'h400, 1'b0, 1'b0, 64'h6);
        exp_obj(5'h05, OFF_STATUS, 32'h11, "status5");
        exp_obj(5'h06, OFF_STATUS, 32'h11, "status6");
        // All members share one filter, and they are read lowest index first.
        setup(5'h08, KIND_PLAIN_RECEIVE, 7'h41, 4'h8, 29'h200, 29'h7F0);
        setup(5'h09, KIND_PLAIN_RECEIVE, 7'h01, 4'h8, 29'h200, 29'h7F0);
        rx(29'h201, 1'b0, 1'b0, 64'h1);
        rx(29'h202, 1'b0, 1'b0, 64'h2);
        rx(29'h203, 1'b0, 1'b0, 64'h3);
        exp_obj(5'h08, OFF_DATA_LO, 32'h1, "data8");
        exp_obj(5'h09, OFF_STATUS, 32'h13, "status9");
        exp_reg(OFF_DATA_LO, 32'h3, "data9");
        wr(OFF_SELECT, 32'h8);
        wr(OFF_STATUS, 32'h1);
        rx(29'h204, 1'b0, 1'b0, 64'h4);
        exp_obj(5'h08, OFF_DATA_LO, 32'h4, "data8");
        setup(5'h0A, KIND_PLAIN_RECEIVE, 7'h04, 4'h8, 29'h55, 29'h0);
        rx(29'h55, 1'b0, 1'b0, 64'h7);
        exp_obj(5'h0A, OFF_STATUS, 32'h10, "status10");
        rx(29'h55, 1'b1, 1'b0, 64'h7);
        exp_obj(5'h0A, OFF_STATUS, 32'h11, "status10");
        setup(5'h0C, KIND_REMOTE_ACCEPT, 7'h02, 4'h8, 29'h77, 29'h0);
        rx(29'h77, 1'b0, 1'b0, 64'h8);
        exp_obj(5'h0C, OFF_STATUS, 32'h10, "status12");
        rx(29'h77, 1'b0, 1'b1, 64'h0);
        exp_obj(5'h0C, OFF_STATUS, 32'h34, "status12");
        chk("irq", 32'h1, {31'h0, irq_pending});
        wr(OFF_STATUS, 32'h1);
        setup(5'h0D, KIND_AUTO_REPLY, 7'h00, 4'h2, 29'h88, 29'h0);
        wr(OFF_DATA_LO, 32'hBEEF);
        rx(29'h88, 1'b0, 1'b1, 64'h0);
        wait_sent(8'h01);
        chk("reply_id", 32'h88, {3'h0, last_sent.id});
        chk("reply_rtr_dlc", 32'h2, {27'h0, last_sent.rtr, last_sent.dlc});
        chk("reply_data", 32'hBEEF, last_sent.data[31:0]);
        tx_delay <= 4'h0;
        setup(5'h0E, KIND_REMOTE_SEND, 7'h10, 4'h4, 29'h99, 29'h0);
        wr(OFF_STATUS, 32'h2);
        wait_sent(8'h02);
        chk("request_frame", 32'h20000099, {2'h0, last_sent.rtr, last_sent.id});
        exp_obj(5'h0E, OFF_CONFIG, 32'h40090, "config14");
        exp_reg(OFF_STATUS, 32'h30, "status14");
        exp_reg(OFF_TX_MAP, 32'h0, "tx_map");
        rx(29'h99, 1'b0, 1'b0, 64'h9);
        exp_obj(5'h0E, OFF_STATUS, 32'h31, "status14");
        setup(5'h14, KIND_PLAIN_RECEIVE, 7'h08, 4'hF, 29'h1ABCDE, 29'h0);
        exp_obj(5'h14, OFF_CONFIG, 32'h80088, "config20");
        exp_reg(OFF_IDENT, 32'h1ABCDE, "ident20");
        be <= 4'h1;
        wr(OFF_IDENT, 32'h000000FF);
        be <= 4'hF;
        exp_reg(OFF_IDENT, 32'h1ABCFF, "ident_byte");
        exp_reg(OFF_VALID_MAP, 32'h107768, "valid_map");
        conclude();
    end
endmodule // test_can_msg_objects
